// ---- design/adv_abilities.sv ----
// Purpose: auto-negotiation advertised abilities register behind the serial management port
// Assumes: nrst held low for at least 3 core_clk edges so strap synchronisers settle
// Notes: straps are sampled while reset is low and loaded on the reset edges
module adv_abilities #(
   parameter logic [4:0] PHY_ADDR = adv_pkg::DEF_PHY_ADDR
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // serial management pins
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe_n,
   // configuration pins
   input wire logic pause_cfg,
   input wire logic [3:0] config_strap_pins,
   // to the negotiation engine
   output logic [15:0] advertised
);
   import adv_pkg::*;

   logic mdc_s1, mdc_s2, mdc_s3;
   logic mdio_s1, mdio_s2;
   logic pause_s1, pause_s2;
   logic [3:0] strap_s1, strap_s2;
   logic mdc_rise;
   logic adv_wr;
   logic [15:0] rdata;
   mgmt_req_t req;

   // ==========================================================
   // pin synchronisers
   always_ff @(posedge core_clk) begin
      mdc_s1 <= mdc;
      mdc_s2 <= mdc_s1;
      mdc_s3 <= mdc_s2;
      mdio_s1 <= mdio_in;
      mdio_s2 <= mdio_s1;
   end

   always_ff @(posedge core_clk) begin
      pause_s1 <= pause_cfg;
      pause_s2 <= pause_s1;
      strap_s1 <= config_strap_pins;
      strap_s2 <= strap_s1;
   end

   assign mdc_rise = mdc_s2 && !mdc_s3;

   // ==========================================================
   // frame handling
   mgmt_frame_slave #(
      .PHY_ADDR(PHY_ADDR)
   ) mgmt_frame_slave_inst (
      .core_clk(core_clk),
      .nrst(nrst),
      .mdc_rise(mdc_rise),
      .mdio_bit(mdio_s2),
      .req(req),
      .rdata(rdata),
      .mdio_out(mdio_out),
      .mdio_oe_n(mdio_oe_n)
   );

   // ==========================================================
   // register
   function automatic logic [15:0] merge_write(input logic [15:0] old, input logic [15:0] wd);
      merge_write = (wd & ADV_WR_MASK) | (old & ~ADV_WR_MASK);
   endfunction

   assign adv_wr = req.wr && (req.addr == ADV_ADDR);

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         advertised <= ADV_FIXED_RESET;
         advertised[PAUSE_BIT] <= pause_s2;
         advertised[SPEED_HI:SPEED_LO] <= strap_s2;
      end else if (adv_wr) begin
         advertised <= merge_write(advertised, req.wdata);
      end
   end

   // unmapped addresses read as zero
   always_comb begin
      rdata = 16'h0000;
      if (req.addr == ADV_ADDR) begin
         rdata = advertised;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   sequence adv_write_s;
      req.wr && (req.addr == ADV_ADDR);
   endsequence

   sequence reset_done_s;
      $rose(nrst);
   endsequence

   a_next_page_wr: assert property (adv_write_s |=>
      advertised[NEXT_PAGE_BIT] == $past(req.wdata[NEXT_PAGE_BIT]))
      else $error("next page bit did not take write");
   a_remote_fault_wr: assert property (adv_write_s |=>
      advertised[REMOTE_FAULT_BIT] == $past(req.wdata[REMOTE_FAULT_BIT]))
      else $error("remote fault bit did not take write");
   a_asym_pause_wr: assert property (adv_write_s |=>
      advertised[ASYM_PAUSE_BIT] == $past(req.wdata[ASYM_PAUSE_BIT]))
      else $error("asymmetric pause bit did not take write");
   a_pause_wr: assert property (adv_write_s |=>
      advertised[PAUSE_BIT] == $past(req.wdata[PAUSE_BIT]))
      else $error("pause bit did not take write");
   a_pause_strap: assert property (reset_done_s |->
      advertised[PAUSE_BIT] == $past(pause_s2))
      else $error("pause bit reset value not from pin");
   a_t4_wr: assert property (adv_write_s |=>
      advertised[T4_BIT] == $past(req.wdata[T4_BIT]))
      else $error("t4 bit did not take write");
   a_speed_wr: assert property (adv_write_s |=>
      advertised[SPEED_HI:SPEED_LO] == $past(req.wdata[SPEED_HI:SPEED_LO]))
      else $error("speed bits did not take write");
   a_speed_strap: assert property (reset_done_s |->
      advertised[SPEED_HI:SPEED_LO] == $past(strap_s2))
      else $error("speed bits reset value not from straps");
   a_fixed_reset: assert property (reset_done_s |->
      advertised[15:11] == 5'h00 && advertised[T4_BIT] == 1'b0 && advertised[SEL_HI:SEL_LO] == ADV_SEL_RESET)
      else $error("fixed reset fields wrong");
   a_reserved_zero: assert property (advertised[RSVD_RO_BIT] == 1'b0)
      else $error("reserved bit 14 not zero");
   a_reserved_rw: assert property (adv_write_s |=>
      advertised[RSVD_RW_BIT] == $past(req.wdata[RSVD_RW_BIT]))
      else $error("reserved bit 12 did not take write");
   a_hold_stable: assert property (!adv_wr ##1 nrst |-> $stable(advertised))
      else $error("register changed without a write");

   // ==========================================================
   // single speed fields and selector
   a_tx_fd_wr: assert property (adv_write_s |=>
      advertised[TX_FD_BIT] == $past(req.wdata[TX_FD_BIT]))
      else $error("100 full duplex bit did not take write");
   a_tx_hd_wr: assert property (adv_write_s |=>
      advertised[TX_HD_BIT] == $past(req.wdata[TX_HD_BIT]))
      else $error("100 half duplex bit did not take write");
   a_t10_fd_wr: assert property (adv_write_s |=>
      advertised[T10_FD_BIT] == $past(req.wdata[T10_FD_BIT]))
      else $error("10 full duplex bit did not take write");
   a_t10_hd_wr: assert property (adv_write_s |=>
      advertised[T10_HD_BIT] == $past(req.wdata[T10_HD_BIT]))
      else $error("10 half duplex bit did not take write");
   a_selector_wr: assert property (adv_write_s |=>
      advertised[SEL_HI:SEL_LO] == $past(req.wdata[SEL_HI:SEL_LO]))
      else $error("selector did not take write");

   // ==========================================================
   // field by field reset values
   a_next_page_rst: assert property (reset_done_s |-> advertised[NEXT_PAGE_BIT] == 1'b0)
      else $error("next page bit reset value wrong");
   a_remote_fault_rst: assert property (reset_done_s |-> advertised[REMOTE_FAULT_BIT] == 1'b0)
      else $error("remote fault bit reset value wrong");
   a_asym_pause_rst: assert property (reset_done_s |-> advertised[ASYM_PAUSE_BIT] == 1'b0)
      else $error("asymmetric pause bit reset value wrong");
   a_t4_rst: assert property (reset_done_s |-> advertised[T4_BIT] == 1'b0)
      else $error("t4 bit reset value wrong");
   a_selector_rst: assert property (reset_done_s |-> advertised[SEL_HI:SEL_LO] == ADV_SEL_RESET)
      else $error("selector reset value wrong");
   a_reserved_rst: assert property (reset_done_s |-> advertised[RSVD_RW_BIT] == 1'b0)
      else $error("reserved bit 12 reset value wrong");

   // ==========================================================
   // read drive on the data pin
   logic [4:0] drive_rises;
   logic [15:0] loaded_word;
   logic [15:0] sent_word;

   always_ff @(posedge core_clk) begin
      if (!nrst || mdio_oe_n) begin
         drive_rises <= 5'h00;
      end else if (mdc_rise) begin
         drive_rises <= drive_rises + 5'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         loaded_word <= 16'h0000;
      end else if (mdc_rise && !mdio_oe_n && drive_rises == 5'h00) begin
         loaded_word <= rdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         sent_word <= 16'h0000;
      end else if (mdc_rise && !mdio_oe_n && drive_rises != 5'h00) begin
         sent_word <= {sent_word[14:0], mdio_out};
      end
   end

   sequence read_sent_s;
      drive_rises == 5'h11;
   endsequence

   a_read_word: assert property (read_sent_s |-> sent_word == loaded_word)
      else $error("read word not shifted out as loaded");
   a_take_line: assert property ($fell(mdio_oe_n) |-> mdio_out == 1'b0)
      else $error("line taken without turnaround zero");
   a_drive_length: assert property (drive_rises <= 5'h11)
      else $error("line driven for too many bits");

endmodule

// ---- design/mgmt_frame_slave.sv ----
// Purpose: serial management frame receiver and read responder
// Assumes: mdc edge and data bit already synchronised to core_clk
// Notes: a new preamble of 32 ones is needed before every frame
module mgmt_frame_slave #(
   parameter logic [4:0] PHY_ADDR = adv_pkg::DEF_PHY_ADDR
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // serial line, synchronised
   input wire logic mdc_rise,
   input wire logic mdio_bit,
   // register side
   output adv_pkg::mgmt_req_t req,
   input wire logic [15:0] rdata,
   // data pin drive
   output logic mdio_out,
   output logic mdio_oe_n
);
   import adv_pkg::*;

   typedef enum logic [2:0] {S_PRE, S_ST, S_OP, S_ADDR, S_TA, S_RDATA, S_WDATA} state_t;

   state_t state;
   logic [5:0] pre_cnt;
   logic [3:0] cnt;
   logic [1:0] op;
   logic [9:0] addr_sh;
   logic [15:0] sh;
   logic is_read;

   // ==========================================================
   // frame sequencer
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         state <= S_PRE;
         pre_cnt <= 6'h00;
         cnt <= 4'h0;
         op <= 2'h0;
         addr_sh <= 10'h000;
         sh <= 16'h0000;
         is_read <= 1'b0;
         req <= '0;
         mdio_out <= 1'b1;
         mdio_oe_n <= 1'b1;
      end else begin
         req.wr <= 1'b0;
         if (mdc_rise) begin
            unique case (state)
               S_PRE: begin
                  if (mdio_bit) begin
                     if (pre_cnt != PREAMBLE_LEN) begin
                        pre_cnt <= pre_cnt + 6'h01;
                     end
                  end else if (pre_cnt == PREAMBLE_LEN) begin
                     state <= S_ST;
                  end else begin
                     pre_cnt <= 6'h00;
                  end
               end
               S_ST: begin
                  pre_cnt <= 6'h00;
                  cnt <= 4'h0;
                  state <= mdio_bit ? S_OP : S_PRE;
               end
               S_OP: begin
                  op <= {op[0], mdio_bit};
                  cnt <= cnt + 4'h1;
                  if (cnt == 4'h1) begin
                     cnt <= 4'h0;
                     state <= S_ADDR;
                  end
               end
               S_ADDR: begin
                  addr_sh <= {addr_sh[8:0], mdio_bit};
                  cnt <= cnt + 4'h1;
                  if (cnt == 4'h9) begin
                     cnt <= 4'h0;
                     req.addr <= {addr_sh[3:0], mdio_bit};
                     is_read <= (op == OP_READ) && (addr_sh[8:4] == PHY_ADDR);
                     state <= (op == OP_READ || op == OP_WRITE) ? S_TA : S_PRE;
                  end
               end
               S_TA: begin
                  cnt <= cnt + 4'h1;
                  if (cnt == 4'h0) begin
                     mdio_out <= 1'b0;
                     mdio_oe_n <= !is_read;
                  end else begin
                     cnt <= 4'h0;
                     mdio_out <= rdata[15];
                     sh <= {rdata[14:0], 1'b0};
                     state <= (op == OP_READ) ? S_RDATA : S_WDATA;
                  end
               end
               S_RDATA: begin
                  cnt <= cnt + 4'h1;
                  mdio_out <= sh[15];
                  sh <= {sh[14:0], 1'b0};
                  if (cnt == 4'hf) begin
                     mdio_out <= 1'b1;
                     mdio_oe_n <= 1'b1;
                     state <= S_PRE;
                  end
               end
               S_WDATA: begin
                  cnt <= cnt + 4'h1;
                  sh <= {sh[14:0], mdio_bit};
                  if (cnt == 4'hf) begin
                     req.wr <= (addr_sh[9:5] == PHY_ADDR);
                     req.wdata <= {sh[14:0], mdio_bit};
                     state <= S_PRE;
                  end
               end
            endcase
         end
      end
   end

endmodule

// ---- inc/adv_pkg.sv ----
// Purpose: shared constants and types for the advertised abilities register block
// Assumes: 16-bit management registers, 5-bit register and station addresses
// Notes: one register is mapped; other addresses read as zero
package adv_pkg;

   // ==========================================================
   // register map
   localparam logic [4:0] ADV_ADDR = 5'h04;
   localparam logic [4:0] DEF_PHY_ADDR = 5'h00;

   // ==========================================================
   // field positions
   localparam int NEXT_PAGE_BIT = 15;
   localparam int RSVD_RO_BIT = 14;
   localparam int REMOTE_FAULT_BIT = 13;
   localparam int RSVD_RW_BIT = 12;
   localparam int ASYM_PAUSE_BIT = 11;
   localparam int PAUSE_BIT = 10;
   localparam int T4_BIT = 9;
   localparam int TX_FD_BIT = 8;
   localparam int TX_HD_BIT = 7;
   localparam int T10_FD_BIT = 6;
   localparam int T10_HD_BIT = 5;
   localparam int SPEED_LO = 5;
   localparam int SPEED_HI = 8;
   localparam int SEL_HI = 4;
   localparam int SEL_LO = 0;

   // ==========================================================
   // reset values and masks
   localparam logic [15:0] ADV_FIXED_RESET = 16'h0001;
   localparam logic [4:0] ADV_SEL_RESET = 5'h01;
   localparam logic [15:0] ADV_WR_MASK = 16'hbfff;

   // ==========================================================
   // management frame
   localparam logic [5:0] PREAMBLE_LEN = 6'h20;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;

   typedef struct packed {
      logic wr;
      logic [4:0] addr;
      logic [15:0] wdata;
   } mgmt_req_t;

endpackage

// ---- test/adv_abilities_bench.sv ----
// Purpose: self-checking bench of the advertised abilities register
// Assumes: station model drives only defined selector codes
// Notes: reset held 20 core_clk
module adv_abilities_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import adv_pkg::*;
   logic core_clk;
   logic nrst;
   logic mdc;
   logic mdio_in;
   logic mdio_out;
   logic mdio_oe_n;
   logic pause_cfg;
   logic [3:0] config_strap_pins;
   logic [15:0] advertised;
   logic [15:0] rv;
   int err_count;
   int comparisons;
   int cycles = 0;

   adv_abilities #(.PHY_ADDR(DEF_PHY_ADDR)) adv_abilities_inst (.core_clk(core_clk), .nrst(nrst), .mdc(mdc),
      .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .pause_cfg(pause_cfg),
      .config_strap_pins(config_strap_pins), .advertised(advertised));
   mgmt_station mgmt_station_inst (.core_clk(core_clk), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
      .mdio_oe_n(mdio_oe_n));

   always #2 core_clk = ~core_clk;

   // ==========================================================
   // checking and closing
   task check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task close_out;
      $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         err_count++;
         close_out;
      end
   end

   task wr(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] d);
      logic [15:0] unused;
      mgmt_station_inst.frame(OP_WRITE, phy, ra, d, unused);
   endtask

   // ==========================================================
   // scenarios
   task test_reset;
      int k;
      logic [15:0] want;
      for (k = 0; k < 2; k++) begin
         @(posedge core_clk);
         pause_cfg <= k[0];
         config_strap_pins <= k[0] ? 4'ha : 4'h5;
         nrst <= 1'b0;
         repeat (20) @(posedge core_clk);
         nrst <= 1'b1;
         repeat (2) @(posedge core_clk);
         want = 16'h0001 | {5'h00, k[0], 10'h000} | {7'h00, (k[0] ? 4'ha : 4'h5), 5'h00};
         check(advertised, want);
         mgmt_station_inst.frame(OP_READ, DEF_PHY_ADDR, ADV_ADDR, 16'h0000, rv);
         check(rv, want);
      end
      $display("test reset done");
   endtask

   task test_bits;
      logic [15:0] vals [13];
      int k;
      // selector codes kept to defined values
      vals = '{16'h8001, 16'h2001, 16'h1001, 16'h0801, 16'h0401, 16'h0201, 16'h0101, 16'h0081, 16'h0041,
               16'h0021, 16'h0002, 16'h4001, 16'hffe1};
      for (k = 0; k < 13; k++) begin
         wr(DEF_PHY_ADDR, ADV_ADDR, vals[k]);
         check(advertised, vals[k] & 16'hbfff);
         mgmt_station_inst.frame(OP_READ, DEF_PHY_ADDR, ADV_ADDR, 16'h0000, rv);
         check(rv, vals[k] & 16'hbfff);
      end
      $display("test bits done");
   endtask

   task test_refuse;
      wr(DEF_PHY_ADDR, ADV_ADDR, 16'h0141);
      wr(5'h01, ADV_ADDR, 16'h0021);
      check(advertised, 16'h0141);
      wr(DEF_PHY_ADDR, 5'h05, 16'h0021);
      mgmt_station_inst.frame(2'h3, DEF_PHY_ADDR, ADV_ADDR, 16'h0021, rv);
      check(advertised, 16'h0141);
      mgmt_station_inst.frame(OP_READ, DEF_PHY_ADDR, 5'h05, 16'h0000, rv);
      check(rv, 16'h0000);
      mgmt_station_inst.frame(OP_READ, 5'h01, ADV_ADDR, 16'h0000, rv);
      check(rv, 16'hffff);
      mgmt_station_inst.frame(OP_READ, DEF_PHY_ADDR, ADV_ADDR, 16'h0000, rv);
      check(rv, 16'h0141);
      $display("test refuse done");
   endtask

   initial begin
      core_clk = 1'b0;
      nrst = 1'b0;
      pause_cfg = 1'b0;
      config_strap_pins = 4'h0;
      err_count = 0;
      comparisons = 0;
      test_reset;
      test_bits;
      test_refuse;
      close_out;
   end
endmodule

// ---- test/mgmt_station.sv ----
// Purpose: station manager model driving management frames
// Assumes: mdc idles low between frames, line pulled up when nobody drives
// Notes: each mdc half period lasts 8 core_clk
module mgmt_station (
   // clock
   input wire logic core_clk,
   // management pins
   output logic mdc,
   output logic mdio_in,
   input wire logic mdio_out,
   input wire logic mdio_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   import adv_pkg::*;
   logic host_en;
   logic host_bit;

   initial begin
      mdc = 1'b0;
      host_en = 1'b0;
      host_bit = 1'b1;
   end

   // wire level: device, then host, else pull-up
   assign mdio_in = !mdio_oe_n ? mdio_out : (host_en ? host_bit : 1'b1);

   // ==========================================================
   // one frame; reads release the line from the turnaround on
   task frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] wd,
              output logic [15:0] rd);
      logic [63:0] bits;
      logic [63:0] drv;
      int i;
      bits = {32'hffffffff, 2'b01, op, phy, ra, 2'b10, wd};
      drv = (op == OP_READ) ? {46'h3fffffffffff, 18'h0} : 64'hffffffffffffffff;
      rd = 16'h0000;
      for (i = 63; i >= 0; i--) begin
         @(posedge core_clk);
         host_en <= drv[i];
         host_bit <= bits[i];
         repeat (7) @(posedge core_clk);
         if (i < 16) rd = {rd[14:0], mdio_in};
         mdc <= 1'b1;
         repeat (8) @(posedge core_clk);
         mdc <= 1'b0;
      end
      @(posedge core_clk);
      host_en <= 1'b0;
      repeat (16) @(posedge core_clk);
   endtask
endmodule
